/* odr_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module odr_adc_model #(
  parameter int DW = 19
) (
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rstn_i,
  // request
  input  wire logic          go_i,
  input  wire logic [DW-1:0] val_i,
  // sample stream
  output logic               s_valid_o,
  output logic      [DW-1:0] s_data_o
);
  // data inverts between samples
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_valid_o <= 1'b0;
      s_data_o  <= '0;
    end else begin
      s_valid_o <= go_i;
      s_data_o  <= go_i ? val_i : ~s_data_o;
    end
  end
endmodule
`default_nettype wire

/* odr_filter.sv */
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R1] replacement off after reset; on only when enable bit written one
// [R2] error is absolute difference of sample and prediction
// [R3] error above threshold marks sample as outlier
// [R4] select zero predicts previous raw sample
// [R5] select one predicts least-squares line over last four outputs
// [R6] error feeds IIR low-pass giving running average deviation
// [R7] threshold is filtered error times 4, 8, 16 or 32
// [R8] time-constant field sets filter constant from 8 to 64 samples
// [R9] initial-value field sets filter state at initialization
// [R10] outlier replaced by prediction, else sample passes unchanged
// [R11] software should set multiplier code 3, others default
// [R12] multiplier codes 0..3 are left shifts by 2..5
// [R13] time-constant codes 0..3 are averaging shifts by 3..6
module odr_filter #(
  parameter int DW = 19
) (
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rstn_i,
  // avalon-mm slave
  input  wire logic [9:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // adc sample stream
  input  wire logic          s_valid_i,
  input  wire logic [DW-1:0] s_data_i,
  // result stream
  output logic               r_valid_o,
  output logic      [DW-1:0] r_data_o,
  output logic               r_outlier_o
);
  localparam int LW = DW + 8;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic [LW-1:0] widen(input logic [DW-1:0] v);
    widen = {8'h00, v};
  endfunction

  function automatic logic [LW-1:0] shl(input logic [LW-1:0] v, input logic [2:0] s);
    logic [LW+7:0] t;
    t = {8'h00, v} << s;
    if (t[LW+7:LW] != 8'h00) begin
      shl = '1;
    end else begin
      shl = t[LW-1:0];
    end
  endfunction

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  localparam int CNT_W_L = odr_pkg::CNT_W;
  logic [7:0] cfg_q;
  logic [CNT_W_L-1:0] cnt_q;
  logic       rd_pend_q;
  logic [31:0] rdata_q;
  logic       wr_hit;
  logic       init_q;

  assign wr_hit = avs_write_i && avs_address_i == odr_pkg::CFG_ADDR && avs_byteenable_i[0];

  // [R1] enable held off at reset
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= odr_pkg::CFG_RESET;
    end else if (wr_hit) begin
      cfg_q <= avs_writedata_i[7:0];
    end
  end

  logic enable;
  logic predictor_select;
  logic [1:0] smoothing_time_constant;
  logic [1:0] smoothing_initial_value;
  logic [1:0] deviation_multiplier;
  assign enable                  = cfg_q[odr_pkg::EN_BIT];
  assign predictor_select        = cfg_q[odr_pkg::ORD_BIT];
  assign smoothing_time_constant = cfg_q[odr_pkg::TC_LSB +: 2];
  assign smoothing_initial_value = cfg_q[odr_pkg::INIT_LSB +: 2];
  assign deviation_multiplier    = cfg_q[odr_pkg::MULT_LSB +: 2];

  // reinitialize on enable rise or any config write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_q <= 1'b1;
    end else begin
      init_q <= wr_hit;
    end
  end

  // ----------------------------------------
  // bus read path, one wait cycle
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read_i && !rd_pend_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && !rd_pend_q) begin
      case (avs_address_i)
        odr_pkg::CFG_ADDR:  rdata_q <= {24'h000000, cfg_q};
        odr_pkg::STAT_ADDR: rdata_q <= {31'h00000000, enable};
        odr_pkg::CNT_ADDR:  rdata_q <= {16'h0000, cnt_q};
        default:            rdata_q <= '0;
      endcase
    end
  end

  assign avs_waitrequest_o = avs_read_i && !rd_pend_q;
  assign avs_readdata_o    = rdata_q;

  // ----------------------------------------
  // prediction
  // ----------------------------------------
  logic [DW-1:0] pred;
  logic [DW-1:0] out_val;
  logic          step;
  assign step = s_valid_i && enable;

  odr_predictor #(
    .DW(DW)
  ) u_pred (
    .ref_clk_i          (ref_clk_i),
    .rstn_i             (rstn_i),
    .init_i             (init_q),
    .predictor_select_i (predictor_select),
    .step_i             (step),
    .raw_i              (s_data_i),
    .out_i              (out_val),
    .pred_o             (pred)
  );

  // ----------------------------------------
  // error, threshold, decision
  // ----------------------------------------
  logic [DW-1:0] err;
  logic [LW-1:0] lpf_q;
  logic [LW-1:0] thr;
  logic          outlier;
  logic          primed_q;

  // [R2] absolute estimation error
  assign err = (s_data_i >= pred) ? s_data_i - pred : pred - s_data_i;

  // [R7] threshold from filtered error
  // [R12] multiplier as left shift
  assign thr = shl(lpf_q, 3'(odr_pkg::MULT_BASE_SH) + {1'b0, deviation_multiplier});

  // [R3] outlier classification
  assign outlier = primed_q && (widen(err) > thr);

  // [R10] replace or pass
  assign out_val = outlier ? pred : s_data_i;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      primed_q <= 1'b0;
    end else if (init_q || !enable) begin
      primed_q <= 1'b0;
    end else if (step) begin
      primed_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // iir low-pass of error
  // ----------------------------------------
  logic [2:0]    tc_sh;
  logic [LW-1:0] lpf_dec;
  logic [LW-1:0] err_inc;
  // [R8] constant 8 to 64
  assign tc_sh   = 3'(odr_pkg::TC_BASE_SH) + {1'b0, smoothing_time_constant};
  assign lpf_dec = lpf_q >> tc_sh;
  assign err_inc = widen(err) >> tc_sh;

  // [R6] running average deviation
  // [R13] shift based averaging
  // [R9] initial state load
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lpf_q <= '0;
    end else if (init_q || !enable) begin
      lpf_q <= shl(widen(DW'(1)), 3'(odr_pkg::INIT_BASE_SH) + {1'b0, smoothing_initial_value});
    end else if (step && primed_q) begin
      lpf_q <= lpf_q - lpf_dec + err_inc;
    end
  end

  // ----------------------------------------
  // outputs and outlier counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_valid_o   <= 1'b0;
      r_data_o    <= '0;
      r_outlier_o <= 1'b0;
    end else begin
      r_valid_o   <= s_valid_i;
      r_data_o    <= enable ? out_val : s_data_i;
      r_outlier_o <= s_valid_i && enable && outlier;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (s_valid_i && enable && outlier) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* odr_filter_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module odr_filter_asserts #(
  parameter int DW = 19
) (
  // clock and reset
  input wire logic          ref_clk_i,
  input wire logic          rstn_i,
  // register bus
  input wire logic [9:0]    avs_address_i,
  input wire logic          avs_read_i,
  input wire logic          avs_write_i,
  input wire logic [31:0]   avs_writedata_i,
  input wire logic [3:0]    avs_byteenable_i,
  input wire logic          avs_waitrequest_o,
  // streams
  input wire logic          s_valid_i,
  input wire logic [DW-1:0] s_data_i,
  input wire logic          r_valid_o,
  input wire logic [DW-1:0] r_data_o,
  input wire logic          r_outlier_o
);
  logic en_q;
  // ----------------------------------------
  // shadow of enable bit
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q <= 1'b0;
    end else if (avs_write_i && avs_byteenable_i[0] && avs_address_i == odr_pkg::CFG_ADDR) begin
      en_q <= avs_writedata_i[odr_pkg::EN_BIT];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence rd_ans;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  sequence smp_out;
    s_valid_i ##1 r_outlier_o;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_VALID_LAT: assert property (s_valid_i |=> r_valid_o)
    else $error("result missing");
  AST_NO_SPUR: assert property (!s_valid_i |=> !r_valid_o)
    else $error("spurious result");
  AST_OUTL_VALID: assert property (r_outlier_o |-> r_valid_o)
    else $error("outlier without result");
  AST_PASS: assert property (s_valid_i ##1 !r_outlier_o |-> r_data_o == $past(s_data_i))
    else $error("sample altered");
  AST_OUTL_DIFF: assert property (smp_out |-> r_data_o != $past(s_data_i))
    else $error("outlier kept sample");
  AST_DIS: assert property (s_valid_i && !en_q && !avs_write_i |=> !r_outlier_o)
    else $error("outlier while off");
  AST_WR_NOWAIT: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  AST_RD_WAIT: assert property ($rose(avs_read_i) |-> rd_ans)
    else $error("read answer late");
endmodule
bind odr_filter odr_filter_asserts #(.DW(DW)) u_chk (.*);
`default_nettype wire

/* odr_filter_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module odr_filter_tb;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i;
  logic [9:0]  avs_address_i = 10'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        s_valid_i;
  logic [18:0] s_data_i;
  logic        r_valid_o;
  logic [18:0] r_data_o;
  logic        r_outlier_o;
  logic        go = 1'b0;
  logic [18:0] val = 19'h0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_out = 0;
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  odr_filter #(.DW(19)) u_dut (.*);
  odr_adc_model #(.DW(19)) u_adc (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .go_i(go),
    .val_i(val), .s_valid_o(s_valid_i), .s_data_o(s_data_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    wrap_up();
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (i == 9) hang();
    if (!w) chk("readdata", d, avs_readdata_o);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic smp(input logic [18:0] v, input logic [18:0] e, input logic eo);
    int i;
    go <= 1'b1;
    val <= v;
    @(posedge ref_clk_i);
    go <= 1'b0;
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk_i);
      if (r_valid_o === 1'b1) break;
    end
    if (i == 6) hang();
    chk("r_data", 32'(e), 32'(r_data_o));
    chk("r_outlier", 32'(eo), 32'(r_outlier_o));
    n_out += 32'(eo);
  endtask
  initial begin
    int k;
    int h;
    logic [31:0] dv;
    rstn_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, odr_pkg::CFG_ADDR, 32'h0);
    bus(1'b0, odr_pkg::STAT_ADDR, 32'h0);
    bus(1'b0, 10'h3fc, 32'h0);
    smp(19'd0, 19'd0, 1'b0);
    smp(19'd60000, 19'd60000, 1'b0);
    bus(1'b1, odr_pkg::CFG_ADDR, 32'h80);
    bus(1'b0, odr_pkg::CFG_ADDR, 32'h80);
    bus(1'b0, odr_pkg::STAT_ADDR, 32'h1);
    smp(19'd0, 19'd0, 1'b0);
    smp(19'd40, 19'd40, 1'b0);
    smp(19'd5000, 19'd40, 1'b1);
    smp(19'd40, 19'd5000, 1'b1);
    for (k = 0; k < 4; k++) begin
      for (h = 0; h < 2; h++) begin
        bus(1'b1, odr_pkg::CFG_ADDR, 32'h80 | k << 4 | k << 2 | k);
        smp(19'd0, 19'd0, 1'b0);
        dv = (h ? 128 : 48) << (2 * k);
        smp(19'(dv), h ? 19'd0 : 19'(dv), h[0]);
      end
    end
    bus(1'b1, odr_pkg::CFG_ADDR, 32'hc0);
    smp(19'd0, 19'd0, 1'b0);
    smp(19'd0, 19'd0, 1'b0);
    smp(19'd20000, 19'd0, 1'b1);
    smp(19'd0, 19'd0, 1'b0);
    bus(1'b1, odr_pkg::CFG_ADDR, 32'h83);
    smp(19'd0, 19'd0, 1'b0);
    smp(19'd40, 19'd40, 1'b0);
    smp(19'd100000, 19'd40, 1'b1);
    bus(1'b0, odr_pkg::CNT_ADDR, 32'(n_out));
    wrap_up();
  end
endmodule
`default_nettype wire

/* odr_pkg.sv */
`default_nettype none
package odr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CFG_IDX      = 8'h16;
  localparam logic [9:0] CFG_ADDR     = 10'h058;
  localparam logic [9:0] STAT_ADDR    = 10'h05c;
  localparam logic [9:0] CNT_ADDR     = 10'h060;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam int         EN_BIT       = 7;
  localparam int         ORD_BIT      = 6;
  localparam int         TC_LSB       = 4;
  localparam int         INIT_LSB     = 2;
  localparam int         MULT_LSB     = 0;
  // ----------------------------------------
  // arithmetic constants
  // ----------------------------------------
  localparam int         MULT_BASE_SH = 2;
  localparam int         TC_BASE_SH   = 3;
  localparam int         INIT_BASE_SH = 4;
  localparam int         HIST_DEPTH   = 4;
  localparam int         CNT_W        = 16;
endpackage
`default_nettype wire

/* odr_predictor.sv */
`timescale 1ns/100ps
`default_nettype none
module odr_predictor #(
  parameter int DW = 19
) (
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rstn_i,
  // control
  input  wire logic          init_i,
  input  wire logic          predictor_select_i,
  // history update
  input  wire logic          step_i,
  input  wire logic [DW-1:0] raw_i,
  input  wire logic [DW-1:0] out_i,
  // prediction
  output logic      [DW-1:0] pred_o
);
  // ----------------------------------------
  // history of raw inputs and outputs
  // ----------------------------------------
  logic [DW-1:0] raw_prev_q;
  logic [DW-1:0] hist_q [odr_pkg::HIST_DEPTH];
  logic signed [DW+3:0] lsq;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_prev_q <= '0;
    end else if (step_i) begin
      raw_prev_q <= raw_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < odr_pkg::HIST_DEPTH; g++) begin : g_hist
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hist_q[g] <= '0;
        end else if (init_i) begin
          hist_q[g] <= '0;
        end else if (step_i) begin
          hist_q[g] <= (g == 0) ? out_i : hist_q[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // prediction
  // ----------------------------------------
  // four-point line fit at next step: p = (2*h0 + h1 - h3) / 2
  always_comb begin
    lsq = (signed'({4'h0, hist_q[0]}) <<< 1)
        + signed'({4'h0, hist_q[1]})
        - signed'({4'h0, hist_q[3]});
    lsq = lsq >>> 1;
  end

  // [R4] previous raw sample
  // [R5] four-output extrapolation
  always_comb begin
    if (!predictor_select_i) begin
      pred_o = raw_prev_q;
    end else if (lsq < 0) begin
      pred_o = '0;
    end else if (lsq[DW+3:DW] != 4'h0) begin
      pred_o = '1;
    end else begin
      pred_o = lsq[DW-1:0];
    end
  end
endmodule
`default_nettype wire
